// ### bench/ccu_props.sv
// Pin-level checks on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module ccu_props (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cpu_reset,
    input wire logic bus_yield_request,
    input wire logic bus_yield_grant,
    input wire logic bus_drive_en,
    input wire logic cpu_data_oe,
    input wire logic addr_strobe_n,
    input wire logic bus_ready_n,
    input wire logic bus_lock_n,
    input wire logic write_not_read,
    input wire logic data_not_control,
    input wire logic mem_not_io,
    input wire logic coproc_working_n,
    input wire logic maskable_irq,
    input wire logic nonmaskable_irq,
    input wire logic [ccu_pkg::LANE_W-1:0] byte_lane_en_n,
    input wire logic [ccu_pkg::ADDR_W-1:0] addr_bus
);
    import ccu_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] rst_cnt_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Saturates so a long link reset never wraps back under the limit
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_cnt_q <= 8'h00;
        else if (!cpu_reset)
            rst_cnt_q <= 8'h00;
        else if (rst_cnt_q != 8'hFF)
            rst_cnt_q <= rst_cnt_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_idle_pins: assert property (cpu_reset |-> addr_strobe_n && byte_lane_en_n == IDLE_LANE_N
        && addr_bus == IDLE_ADDR && !write_not_read && data_not_control && !mem_not_io && bus_lock_n
        && !bus_yield_grant && !cpu_data_oe) else $error("idle pins wrong in reset");
    a_grant_floats: assert property (bus_yield_grant |-> !bus_drive_en && !cpu_data_oe)
        else $error("pins driven during grant");
    a_reset_beats_hold: assert property (cpu_reset && bus_yield_request |-> !bus_yield_grant && bus_drive_en)
        else $error("grant during reset");
    a_grant_release: assert property (bus_yield_grant && !bus_yield_request |=> !bus_yield_grant)
        else $error("grant held after request drop");
    a_inta_pair: assert property ($fell(bus_lock_n) && !mem_not_io && !data_not_control |-> !addr_strobe_n
        ##1 !bus_ready_n && addr_strobe_n ##1 !addr_strobe_n && !bus_lock_n) else $error("acknowledge pair broken");
    a_irq_held_ack: assert property ($fell(maskable_irq) && !cpu_reset && !$past(cpu_reset)
        |-> !$past(addr_strobe_n) || !$past(addr_strobe_n, 2)) else $error("irq dropped before acknowledge");
    a_nmi_shape: assert property ($rose(nonmaskable_irq) |-> !$past(nonmaskable_irq, 8)
        ##0 nonmaskable_irq[*8]) else $error("nmi pulse too short");
    a_reset_length: assert property ($fell(cpu_reset) |-> rst_cnt_q >= (coproc_working_n ? 8'h0F : 8'h50))
        else $error("link reset too short");
    c_grant: cover property ($rose(bus_yield_grant));
    c_inta: cover property ($fell(bus_lock_n) ##2 !addr_strobe_n);
    c_nmi: cover property ($rose(nonmaskable_irq));
endmodule : ccu_props
`default_nettype wire

// ### bench/cpu_control_inputs_unit_tb.sv
// Self-checking bench joining the processor end to the surrounding logic
`timescale 1ns/1ps
`default_nettype none
module cpu_control_inputs_unit_tb;
    import ccu_pkg::*;
    logic core_clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic valid = 1'h0, opw = 1'h0, irq_en = 1'h0, irtn = 1'h0, reset_req = 1'h0, selftest = 1'h0;
    logic master = 1'h0, opreq = 1'h0, busy = 1'h0, fault = 1'h0, mirq = 1'h0, nmi = 1'h0;
    ccu_insn_t cls = CCU_INSN_OTHER;
    logic [ADDR_W-1:0] opa = 30'h0;
    logic [VEC_W-1:0] vec = 8'h00;
    logic ready, exc, done, st_req, nmi_act;
    logic [VEC_W-1:0] exc_vec;
    logic [DATA_W-1:0] rdata;
    int failures = 0, comparisons = 0, exc_cnt = 0, i, n, k;
    ccu_if link ();
    ccu_cpu_end ccu_cpu_end_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'h1), .link(link),
        .insn_valid_i(valid), .insn_class_i(cls), .insn_opnd_write_i(opw), .insn_opnd_addr_i(opa),
        .insn_opnd_wdata_i({2'h0, opa}), .insn_ready_o(ready), .irq_enable_flag_i(irq_en),
        .irq_return_insn_i(irtn), .exc_valid_o(exc), .exc_vector_o(exc_vec), .opnd_rdata_o(rdata),
        .opnd_done_o(done), .selftest_req_o(st_req), .nmi_active_o(nmi_act));
    ccu_far_end ccu_far_end_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'h1), .link(link),
        .reset_req_i(reset_req), .selftest_i(selftest), .master_req_i(master), .master_owns_o(),
        .cp_opreq_i(opreq), .cp_busy_i(busy), .cp_fault_i(fault), .mirq_req_i(mirq), .mirq_vector_i(vec),
        .nmi_req_i(nmi), .in_reset_o());
    ccu_props ccu_props_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cpu_reset(link.cpu_reset),
        .bus_yield_request(link.bus_yield_request), .bus_yield_grant(link.bus_yield_grant),
        .bus_drive_en(link.bus_drive_en), .cpu_data_oe(link.cpu_data_oe), .addr_strobe_n(link.addr_strobe_n),
        .bus_ready_n(link.bus_ready_n), .bus_lock_n(link.bus_lock_n), .write_not_read(link.write_not_read),
        .data_not_control(link.data_not_control), .mem_not_io(link.mem_not_io),
        .coproc_working_n(link.coproc_working_n), .maskable_irq(link.maskable_irq),
        .nonmaskable_irq(link.nonmaskable_irq), .byte_lane_en_n(link.byte_lane_en_n), .addr_bus(link.addr_bus));
    always #10 core_clk_i = ~core_clk_i;
    // Off the launching edge so a one-cycle pulse is never missed
    always @(negedge core_clk_i) if (exc === 1'h1) exc_cnt++;
    ////////////////////////////////////////////////////////////////////////////////
    task cyc(input int c);
        repeat (c) @(posedge core_clk_i);
        #1;
    endtask : cyc
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task final_report;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task bound(input int c);
        if (c >= 200)
        begin
            failures++;
            final_report();
        end
    endtask : bound
    task offer(input ccu_insn_t c);
        valid = 1'h1;
        cls = c;
        #1;
        for (i = 0; i < 200 && ready !== 1'h1; i++) cyc(1);
        bound(i);
        cyc(1);
        valid = 1'h0;
    endtask : offer
    task wait_exc(input int c);
        for (i = 0; i < 200 && exc_cnt == c; i++) cyc(1);
        bound(i);
        cyc(1);
    endtask : wait_exc
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk(link.cpu_reset, 1'h1);
        chk({link.addr_strobe_n, link.byte_lane_en_n, link.write_not_read, link.data_not_control, link.mem_not_io,
            link.bus_lock_n, link.bus_yield_grant, link.cpu_data_oe}, 11'h414);
        chk(link.addr_bus, IDLE_ADDR);
        for (i = 0; i < 200 && link.cpu_reset !== 1'h0; i++) cyc(1);
        bound(i);
        cyc(2);
        chk(st_req, 1'h0);
    endtask : t_reset
    task t_mirq;
        k = exc_cnt;
        vec = 8'hA5;
        mirq = 1'h1;
        cyc(1);
        mirq = 1'h0;
        cyc(20);
        chk(exc_cnt - k, 0);
        irq_en = 1'h1;
        wait_exc(k);
        chk(exc_vec, 8'hA5);
    endtask : t_mirq
    task t_fault;
        fault = 1'h1;
        cyc(6);
        for (n = 0; n < 12; n++)
        begin
            k = exc_cnt;
            offer(ccu_insn_t'(n));
            cyc(2);
            chk(exc_cnt - k, (n >= 2 && n <= 10) ? 0 : 1);
            if (n < 2 || n > 10)
                chk(exc_vec, COPROC_EXC_VECTOR);
        end
        fault = 1'h0;
    endtask : t_fault
    task t_busy;
        busy = 1'h1;
        cyc(6);
        valid = 1'h1;
        cls = CCU_INSN_STACK;
        cyc(10);
        chk(ready, 1'h0);
        busy = 1'h0;
        offer(CCU_INSN_STACK);
        busy = 1'h1;
        cyc(6);
        valid = 1'h1;
        cls = CCU_INSN_INIT;
        #1;
        chk(ready, 1'h1);
        cyc(1);
        valid = 1'h0;
        busy = 1'h0;
        cyc(6);
    endtask : t_busy
    task t_opnd;
        opa = 30'h0123456;
        for (k = 0; k < 2; k++)
        begin
            opw = k[0];
            offer(CCU_INSN_OTHER);
            opreq = 1'h1;
            for (i = 0; i < 200 && link.addr_strobe_n !== 1'h0; i++) cyc(1);
            bound(i);
            chk({link.write_not_read, link.addr_bus}, {opw, opa});
            opreq = 1'h0;
            for (i = 0; i < 200 && done !== 1'h1; i++) cyc(1);
            bound(i);
            chk(rdata, BUS_PULLUP);
        end
    endtask : t_opnd
    task t_grant_nmi;
        master = 1'h1;
        for (i = 0; i < 200 && link.bus_yield_grant !== 1'h1; i++) cyc(1);
        bound(i);
        chk({link.bus_drive_en, link.cpu_data_oe}, 2'h0);
        k = exc_cnt;
        nmi = 1'h1;
        cyc(1);
        nmi = 1'h0;
        cyc(30);
        chk(exc_cnt - k, 0);
        master = 1'h0;
        wait_exc(k);
        chk({nmi_act, exc_vec}, {1'h1, NMI_VECTOR});
        nmi = 1'h1;
        cyc(1);
        nmi = 1'h0;
        cyc(30);
        chk(exc_cnt - k, 1);
        irtn = 1'h1;
        cyc(1);
        irtn = 1'h0;
        wait_exc(k + 1);
        chk(exc_vec, NMI_VECTOR);
        irtn = 1'h1;
        cyc(1);
        irtn = 1'h0;
        cyc(2);
        chk(nmi_act, 1'h0);
    endtask : t_grant_nmi
    task t_reset_grant;
        master = 1'h1;
        selftest = 1'h1;
        for (i = 0; i < 200 && link.bus_yield_grant !== 1'h1; i++) cyc(1);
        bound(i);
        reset_req = 1'h1;
        cyc(1);
        reset_req = 1'h0;
        for (i = 0; i < 200 && link.cpu_reset !== 1'h1; i++) cyc(1);
        bound(i);
        chk(link.bus_yield_grant, 1'h0);
        master = 1'h0;
        for (n = 0; n < 200 && link.cpu_reset === 1'h1; n++) cyc(1);
        bound(n);
        chk(n >= RESET_SELFTEST_CYC, 1'h1);
        selftest = 1'h0;
        cyc(2);
        chk(st_req, 1'h1);
    endtask : t_reset_grant
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(4);
        rst_n_i = 1'h1;
        t_reset();
        t_mirq();
        t_fault();
        t_busy();
        t_opnd();
        t_grant_nmi();
        t_reset_grant();
        final_report();
    end
endmodule : cpu_control_inputs_unit_tb
`default_nettype wire

// ### rtl/ccu_cpu_end.sv
// Processor end: bus grant, coprocessor handshake, interrupts and reset entry
`timescale 1ns/1ps
`default_nettype none
module ccu_cpu_end (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    ccu_if.cpu_end link,
    input wire logic insn_valid_i,
    input wire ccu_pkg::ccu_insn_t insn_class_i,
    input wire logic insn_opnd_write_i,
    input wire logic [ccu_pkg::ADDR_W-1:0] insn_opnd_addr_i,
    input wire logic [ccu_pkg::DATA_W-1:0] insn_opnd_wdata_i,
    output logic insn_ready_o,
    input wire logic irq_enable_flag_i,
    input wire logic irq_return_insn_i,
    output logic exc_valid_o,
    output logic [ccu_pkg::VEC_W-1:0] exc_vector_o,
    output logic [ccu_pkg::DATA_W-1:0] opnd_rdata_o,
    output logic opnd_done_o,
    output logic selftest_req_o,
    output logic nmi_active_o
);
    import ccu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: stage 0 feeds only stage 1
    logic [4:0] async_in;
    logic [4:0] sync0_q;
    logic [4:0] sync1_q;
    logic nmi_prev_q;
    logic opreq_s;
    logic busy_s;
    logic fault_s;
    logic mirq_s;
    logic nmi_s;

    assign async_in = {link.nonmaskable_irq, link.maskable_irq, link.coproc_fault_n,
                       link.coproc_working_n, link.coproc_operand_request};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    sync0_q[gi] <= 1'b0;
                    sync1_q[gi] <= 1'b0;
                end
                else if (ce_i)
                begin
                    sync0_q[gi] <= async_in[gi];
                    sync1_q[gi] <= sync0_q[gi];
                end
            end
        end
    endgenerate

    assign opreq_s = sync1_q[0];
    assign busy_s = !sync1_q[1];
    assign fault_s = !sync1_q[2];
    assign mirq_s = sync1_q[3];
    assign nmi_s = sync1_q[4];

    ////////////////////////////////////////////////////////////////////////
    // Self-test strap taken at the release of link reset
    logic reset_prev_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reset_prev_q <= 1'b1;
            selftest_req_o <= 1'b0;
        end
        else if (ce_i)
        begin
            reset_prev_q <= link.cpu_reset;
            if (link.cpu_reset)
                selftest_req_o <= 1'b0;
            else if (reset_prev_q)
                selftest_req_o <= busy_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    ccu_state_t state_q;
    logic strobe_q;
    logic cyc_done;
    logic nmi_pend_q;
    logic nmi_take;
    logic mirq_take;
    logic opnd_take;
    logic insn_accept;
    logic opnd_write_q;
    logic [ADDR_W-1:0] opnd_addr_q;
    logic [DATA_W-1:0] opnd_wdata_q;

    // Ready is ignored in the strobe state of each cycle
    assign cyc_done = !strobe_q && !link.bus_ready_n;
    assign nmi_take = (state_q == CCU_ST_IDLE) && !link.bus_yield_request && nmi_pend_q && !nmi_active_o;
    assign mirq_take = (state_q == CCU_ST_IDLE) && !link.bus_yield_request && !nmi_take
                       && mirq_s && irq_enable_flag_i;
    // Synced request lags the pin; hold off one cycle after a transfer
    assign opnd_take = (state_q == CCU_ST_IDLE) && !link.bus_yield_request && !nmi_take
                       && !mirq_take && !opnd_done_o && opreq_s;
    // Init and clear never stall on busy
    assign insn_ready_o = !link.cpu_reset && (state_q == CCU_ST_IDLE) && !link.bus_yield_request
                          && !nmi_take && !mirq_take && !opnd_take
                          && !(ccu_needs_wait(insn_class_i) && busy_s);
    assign insn_accept = insn_valid_i && insn_ready_o;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= CCU_ST_IDLE;
            strobe_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (link.cpu_reset)
            begin
                state_q <= CCU_ST_IDLE;
                strobe_q <= 1'b0;
            end
            else
            begin
                strobe_q <= 1'b0;
                unique case (state_q)
                    CCU_ST_IDLE:
                    begin
                        if (link.bus_yield_request)
                            state_q <= CCU_ST_GRANT;
                        else if (mirq_take || opnd_take)
                        begin
                            state_q <= mirq_take ? CCU_ST_INTA1 : CCU_ST_OPND;
                            strobe_q <= 1'b1;
                        end
                    end
                    CCU_ST_INTA1:
                    begin
                        if (cyc_done)
                        begin
                            state_q <= CCU_ST_INTA2;
                            strobe_q <= 1'b1;
                        end
                    end
                    CCU_ST_INTA2, CCU_ST_OPND:
                    begin
                        if (cyc_done)
                            state_q <= CCU_ST_IDLE;
                    end
                    CCU_ST_GRANT:
                    begin
                        if (!link.bus_yield_request)
                            state_q <= CCU_ST_IDLE;
                    end
                    default:
                        state_q <= CCU_ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored coprocessor opcode operands
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            opnd_write_q <= 1'b0;
            opnd_addr_q <= '0;
            opnd_wdata_q <= '0;
        end
        else if (ce_i && insn_accept)
        begin
            opnd_write_q <= insn_opnd_write_i;
            opnd_addr_q <= insn_opnd_addr_i;
            opnd_wdata_q <= insn_opnd_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // NMI edge memory: a new edge wins over the take
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
            nmi_active_o <= 1'b0;
        end
        else if (ce_i)
        begin
            nmi_prev_q <= nmi_s;
            if (link.cpu_reset)
            begin
                nmi_pend_q <= 1'b0;
                nmi_active_o <= 1'b0;
            end
            else
            begin
                if (nmi_s && !nmi_prev_q)
                    nmi_pend_q <= 1'b1;
                else if (nmi_take)
                    nmi_pend_q <= 1'b0;
                if (nmi_take)
                    nmi_active_o <= 1'b1;
                else if (irq_return_insn_i)
                    nmi_active_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exceptions, vectors and operand completion
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            exc_valid_o <= 1'b0;
            exc_vector_o <= '0;
            opnd_rdata_o <= '0;
            opnd_done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            exc_valid_o <= 1'b0;
            opnd_done_o <= 1'b0;
            if (!link.cpu_reset)
            begin
                if (nmi_take)
                begin
                    exc_valid_o <= 1'b1;
                    exc_vector_o <= NMI_VECTOR;
                end
                else if (state_q == CCU_ST_INTA2 && cyc_done)
                begin
                    exc_valid_o <= 1'b1;
                    exc_vector_o <= link.data_bus[VEC_W-1:0];
                end
                else if (insn_accept && fault_s && !ccu_fault_exempt(insn_class_i))
                begin
                    exc_valid_o <= 1'b1;
                    exc_vector_o <= COPROC_EXC_VECTOR;
                end
                if (state_q == CCU_ST_OPND && cyc_done)
                begin
                    opnd_done_o <= 1'b1;
                    if (!opnd_write_q)
                        opnd_rdata_o <= link.data_bus;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; idle levels outside cycles and in reset
    logic inta_cyc;
    logic opnd_cyc;

    assign inta_cyc = (state_q == CCU_ST_INTA1) || (state_q == CCU_ST_INTA2);
    assign opnd_cyc = (state_q == CCU_ST_OPND);
    assign link.bus_yield_grant = !link.cpu_reset && (state_q == CCU_ST_GRANT);
    assign link.bus_drive_en = link.cpu_reset || (state_q != CCU_ST_GRANT);
    assign link.addr_strobe_n = !(strobe_q && !link.cpu_reset);
    assign link.byte_lane_en_n = IDLE_LANE_N;
    assign link.addr_bus = (opnd_cyc && !link.cpu_reset) ? opnd_addr_q : IDLE_ADDR;
    assign link.write_not_read = opnd_cyc && opnd_write_q && !link.cpu_reset;
    assign link.data_not_control = link.cpu_reset || !inta_cyc;
    assign link.mem_not_io = opnd_cyc && !link.cpu_reset;
    assign link.bus_lock_n = !(inta_cyc && !link.cpu_reset);
    assign link.cpu_data_out = opnd_wdata_q;
    assign link.cpu_data_oe = opnd_cyc && opnd_write_q && !link.cpu_reset;
endmodule : ccu_cpu_end
`default_nettype wire

// ### rtl/ccu_far_end.sv
// Surrounding logic: reset source, bus master, coprocessor and irq controller
`timescale 1ns/1ps
`default_nettype none
module ccu_far_end (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    ccu_if.far_end link,
    input wire logic reset_req_i,
    input wire logic selftest_i,
    input wire logic master_req_i,
    output logic master_owns_o,
    input wire logic cp_opreq_i,
    input wire logic cp_busy_i,
    input wire logic cp_fault_i,
    input wire logic mirq_req_i,
    input wire logic [ccu_pkg::VEC_W-1:0] mirq_vector_i,
    input wire logic nmi_req_i,
    output logic in_reset_o
);
    import ccu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset pulse, lengthened when a self-test is asked for
    logic [RESET_CNT_W-1:0] rst_cnt_q;
    logic selftest_q;
    logic reset_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_cnt_q <= RESET_CNT_W'(RESET_MIN_CYC);
            selftest_q <= 1'b0;
            reset_q <= 1'b1;
        end
        else if (ce_i)
        begin
            if (reset_req_i && !reset_q)
            begin
                selftest_q <= selftest_i;
                rst_cnt_q <= selftest_i ? RESET_CNT_W'(RESET_SELFTEST_CYC)
                                        : RESET_CNT_W'(RESET_MIN_CYC);
                reset_q <= 1'b1;
            end
            else if (rst_cnt_q > RESET_CNT_W'(1))
                rst_cnt_q <= rst_cnt_q - RESET_CNT_W'(1);
            else
                reset_q <= 1'b0;
        end
    end

    assign link.cpu_reset = reset_q;
    assign in_reset_o = reset_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus master and coprocessor pins
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            link.bus_yield_request <= 1'b0;
            link.coproc_operand_request <= 1'b0;
            link.coproc_working_n <= 1'b1;
            link.coproc_fault_n <= 1'b1;
        end
        else if (ce_i)
        begin
            // Request stays up for the whole ownership
            link.bus_yield_request <= master_req_i && !reset_q;
            link.coproc_operand_request <= cp_opreq_i;
            link.coproc_working_n <= reset_q ? !selftest_q : !cp_busy_i;
            link.coproc_fault_n <= !cp_fault_i;
        end
    end

    assign master_owns_o = link.bus_yield_grant && link.bus_yield_request;

    ////////////////////////////////////////////////////////////////////////
    // Maskable request held until the first acknowledge strobe
    logic inta_seen;

    assign inta_seen = !link.addr_strobe_n && !link.mem_not_io && !link.data_not_control
                       && !link.write_not_read;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            link.maskable_irq <= 1'b0;
        else if (ce_i)
        begin
            if (mirq_req_i)
                link.maskable_irq <= 1'b1;
            else if (inta_seen)
                link.maskable_irq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // NMI shaper: low then high for the minimum spans
    logic nmi_pend_q;
    logic [3:0] nmi_cnt_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nmi_pend_q <= 1'b0;
            nmi_cnt_q <= '0;
            link.nonmaskable_irq <= 1'b0;
        end
        else if (ce_i)
        begin
            if (nmi_req_i)
                nmi_pend_q <= 1'b1;
            if (nmi_cnt_q != 4'h0)
                nmi_cnt_q <= nmi_cnt_q - 4'h1;
            else if (link.nonmaskable_irq)
                link.nonmaskable_irq <= 1'b0;
            else if (nmi_pend_q)
                nmi_cnt_q <= 4'(NMI_MIN_CYC);
            if (nmi_cnt_q == 4'h1 && !link.nonmaskable_irq && nmi_pend_q)
            begin
                link.nonmaskable_irq <= 1'b1;
                nmi_cnt_q <= 4'(NMI_MIN_CYC);
                nmi_pend_q <= nmi_req_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus responder: ready in the second state, vector on acknowledge
    logic cyc_q;
    logic inta_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cyc_q <= 1'b0;
            inta_q <= 1'b0;
        end
        else if (ce_i)
        begin
            cyc_q <= !link.addr_strobe_n;
            if (!link.addr_strobe_n)
                inta_q <= inta_seen;
        end
    end

    assign link.bus_ready_n = !cyc_q;
    assign link.far_data_oe = cyc_q && inta_q;
    assign link.far_data_out = {{(DATA_W-VEC_W){1'b0}}, mirq_vector_i};
endmodule : ccu_far_end
`default_nettype wire

// ### rtl/ccu_if.sv
// Pin-level link between the processor end and the surrounding logic
`timescale 1ns/1ps
`default_nettype none
interface ccu_if;
    import ccu_pkg::*;
    logic cpu_reset;
    logic bus_yield_request;
    logic bus_yield_grant;
    logic coproc_operand_request;
    logic coproc_working_n;
    logic coproc_fault_n;
    logic maskable_irq;
    logic nonmaskable_irq;
    logic bus_ready_n;
    logic bus_drive_en;
    logic addr_strobe_n;
    logic write_not_read;
    logic data_not_control;
    logic mem_not_io;
    logic bus_lock_n;
    logic [LANE_W-1:0] byte_lane_en_n;
    logic [ADDR_W-1:0] addr_bus;
    logic [DATA_W-1:0] cpu_data_out;
    logic cpu_data_oe;
    logic [DATA_W-1:0] far_data_out;
    logic far_data_oe;
    logic [DATA_W-1:0] data_bus;

    // Undriven bus reads as the pull-ups
    assign data_bus = cpu_data_oe ? cpu_data_out : (far_data_oe ? far_data_out : BUS_PULLUP);

    modport cpu_end (
        input cpu_reset, bus_yield_request, coproc_operand_request, coproc_working_n,
        input coproc_fault_n, maskable_irq, nonmaskable_irq, bus_ready_n, data_bus,
        output bus_yield_grant, bus_drive_en, addr_strobe_n, write_not_read, data_not_control,
        output mem_not_io, bus_lock_n, byte_lane_en_n, addr_bus, cpu_data_out, cpu_data_oe
    );
    modport far_end (
        output cpu_reset, bus_yield_request, coproc_operand_request, coproc_working_n,
        output coproc_fault_n, maskable_irq, nonmaskable_irq, bus_ready_n, far_data_out, far_data_oe,
        input bus_yield_grant, bus_drive_en, addr_strobe_n, write_not_read, data_not_control,
        input mem_not_io, bus_lock_n, byte_lane_en_n, addr_bus, data_bus
    );
endinterface : ccu_if
`default_nettype wire

// ### rtl/ccu_pkg.sv
// Shared constants, types and decode helpers for the control-input unit
package ccu_pkg;
    localparam int ADDR_W = 30;
    localparam int DATA_W = 32;
    localparam int LANE_W = 4;
    localparam int VEC_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [VEC_W-1:0] NMI_VECTOR = 8'h02;
    localparam logic [VEC_W-1:0] COPROC_EXC_VECTOR = 8'h10;
    localparam int NMI_MIN_CYC = 8;
    localparam int RESET_MIN_CYC = 15;
    localparam int RESET_SELFTEST_CYC = 80;
    localparam int RESET_CNT_W = 7;
    localparam logic [ADDR_W-1:0] IDLE_ADDR = 30'h3FFFFFFF;
    localparam logic [LANE_W-1:0] IDLE_LANE_N = 4'h0;
    localparam logic [DATA_W-1:0] BUS_PULLUP = 32'hFFFFFFFF;

    typedef enum logic [3:0] {
        CCU_INSN_STACK = 4'h0,
        CCU_INSN_WAIT = 4'h1,
        CCU_INSN_INIT = 4'h2,
        CCU_INSN_CLEAR_EXC = 4'h3,
        CCU_INSN_STORE_STATUS = 4'h4,
        CCU_INSN_STORE_STATUS_ACC = 4'h5,
        CCU_INSN_STORE_CTRL = 4'h6,
        CCU_INSN_STORE_ENV = 4'h7,
        CCU_INSN_SAVE_STATE = 4'h8,
        CCU_INSN_STORE_ENV_ALT = 4'h9,
        CCU_INSN_SAVE_STATE_ALT = 4'hA,
        CCU_INSN_OTHER = 4'hB
    } ccu_insn_t;

    typedef enum logic [2:0] {
        CCU_ST_IDLE = 3'h0,
        CCU_ST_INTA1 = 3'h1,
        CCU_ST_INTA2 = 3'h3,
        CCU_ST_OPND = 3'h2,
        CCU_ST_GRANT = 3'h4
    } ccu_state_t;

    function automatic logic ccu_needs_wait(input ccu_insn_t c);
        return (c == CCU_INSN_STACK) || (c == CCU_INSN_WAIT);
    endfunction : ccu_needs_wait

    function automatic logic ccu_fault_exempt(input ccu_insn_t c);
        return (c >= CCU_INSN_INIT) && (c <= CCU_INSN_SAVE_STATE_ALT);
    endfunction : ccu_fault_exempt
endpackage : ccu_pkg
